/* logic/frame_cmd_regs.vh */
/*
  Constants of the frame-memory write and configuration block: command
  identifiers, register field positions, reset values and link framing.
  Assumes inclusion by bare name from the design file and the testbench.
*/
`ifndef FRAME_CMD_REGS_VH
`define FRAME_CMD_REGS_VH
// ============================================================
// Command identifiers
`define CMD_CFG0_WR      16'hAA00
`define CMD_CFG0_RD      16'hAA60
`define CMD_CFG1_WR      16'hAA01
`define CMD_CFG1_RD      16'hAA61
`define CMD_OPEN_LOC_WR  16'hAA0E
`define CMD_OPEN_LOC_RD  16'hAA6E
`define CMD_SHORT_LOC_WR 16'hAA0F
`define CMD_SHORT_LOC_RD 16'hAA6F
`define CMD_LINE_OPEN_HI 16'hAAA0
`define CMD_LINE_OPEN_LO 16'hAAA1
`define CMD_LINE_SHRT_HI 16'hAAA2
`define CMD_LINE_SHRT_LO 16'hAAA3
`define CMD_CH_OPEN      16'hAAA4
`define CMD_CH_SHORT     16'hAAA5
`define CMD_FRAME_SYNC   16'hAAF0
`define CMD_MATRIX_PSAVE 16'hAA90
`define CMD_STBY_CLEAR   16'hAAB0
`define CMD_STBY_ENABLE  16'hAAB1
`define CMD_SOFT_RESET   16'hAA80
`define CMD_GS_WRITE     16'hAA30
// ============================================================
// Field positions in common_config_zero
`define CFG0_SCAN_LSB    16
`define CFG0_SCAN_MSB    21
`define CFG0_SUBP_LSB    22
`define CFG0_SUBP_MSB    24
// Field positions in common_config_one
`define CFG1_SEG_LSB     0
`define CFG1_SEG_MSB     9
`define CFG1_THR_LSB     10
`define CFG1_THR_MSB     24
`define CFG1_SWT_LSB     37
`define CFG1_SWT_MSB     40
// ============================================================
// Reset values
`define CFG0_RESET       48'h2000_E000_0107
`define CFG1_RESET       48'h0000_0000_0000
`define LOC_RESET        48'h0000_0000_0000
// ============================================================
// Link framing: start bit, then command and data bits; then channels per memory line
`define LINK_CMD_BITS    16
`define LINK_DATA_BITS   48
`define LINK_FRAME_BITS  7'd64
`define CHANNELS_PER_LINE 5'd16
`endif

/* logic/frame_cmd.v */
/*
  Command interpreter of a matrix LED driver: serial command receiver,
  command FIFO, configuration registers, frame-memory write addressing
  and the sub-period / segment display timing.
  Assumes sclk and sin come from the display controller, asynchronous to
  clk; grayscale memory and warning detectors sit outside this block.
*/
// How it works
// - Power-on clears bank flag, line, channel counters.
// - First word after frame sync: current bank, line0 ch0.
// - Grayscale write stores word, channel counter increments.
// - After sixteenth write channel wraps, line advances.
// - Frame ends past scan count; line returns zero.
// - Frame split into sub-periods from config field.
// - Each sub-period has one segment per line.
// - Segment is display interval then switch interval.
// - Threshold sets minimum on-time and active sub-periods.
// - Open and short line locators are read/write.
// - Line open warnings readable by two commands.
// - Line short warnings readable by two commands.
// - Channel open and short warnings are readable.
// - Frame sync command identifier decoded.
// - Matrix power-saving command accepted, write only.
// - Standby clear command accepted, write only.
// - Standby enable command accepted, write only.
// - Soft reset restores registers, memory untouched.
// - Memory data transfers use their own identifier.
// - Sub-period code gives 16 to 128 steps.
// - Scan code gives lines minus one.
`timescale 1ns/10ps
`include "frame_cmd_regs.vh"

// ============================================================
// Command FIFO
module cmd_fifo
#(
  parameter WIDTH = 64,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  // Clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Word storage
  reg [AW:0]      wr_ptr;           // Extra bit tells full from empty
  reg [AW:0]      rd_ptr;
  wire            full;
  wire            empty;
  integer         i;

  assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
                     (wr_ptr[AW] != rd_ptr[AW]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Pointer and storage update
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {WIDTH{1'b0}};
    end
    else
    begin
      if (in_valid && !full)
      begin
        mem[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // cmd_fifo

// ============================================================
// Top: command interpreter
module frame_cmd
(
  // Clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // Serial command link
  input  wire        sclk,
  input  wire        sin,
  output reg         sout,
  output wire        link_ready,
  output reg         link_overflow,
  // Grayscale memory write port
  output reg         mem_we,
  output reg         mem_bank,
  output reg  [5:0]  mem_line,
  output reg  [3:0]  mem_channel,
  output reg  [47:0] mem_wdata,
  output reg         bank_select,
  output reg         frame_done,
  // Warning inputs from detectors
  input  wire [63:0] line_open_warn,
  input  wire [63:0] line_short_warn,
  input  wire [47:0] ch_open_warn,
  input  wire [47:0] ch_short_warn,
  // Configuration and mode outputs
  output reg  [47:0] open_locator,
  output reg  [47:0] short_locator,
  output reg         standby,
  output reg         psave_pulse,
  // Display timing
  input  wire [15:0] probe_gs,
  output reg  [5:0]  scan_line,
  output reg  [6:0]  subperiod,
  output reg         seg_display,
  output reg         line_switch,
  output reg         led_on
);
  // ==========================================================
  // Link sampling and frame receiver
  reg        sclk_s1, sclk_s2, sclk_s3;  // Two-stage sync, then edge ref
  reg        sin_s1, sin_s2;
  reg        rx_busy;                    // Inside a frame
  reg  [6:0] rx_cnt;                     // Bits received in frame
  reg [63:0] rx_sh;                      // Command then data
  reg        rx_push;                    // One-cycle FIFO write
  reg [47:0] reply_sh;                   // Reply shifted out next frame
  reg        reply_pend;                 // Reply loaded, not yet sent
  wire       sclk_rise = sclk_s2 && !sclk_s3;
  wire       sclk_fall = !sclk_s2 && sclk_s3;
  wire       fifo_valid;
  wire [63:0] fifo_data;
  wire       fifo_ready;
  // Executor decisions
  wire [15:0] cmd  = fifo_data[63:48];
  wire [47:0] data = fifo_data[47:0];
  reg  [47:0] cfg0;                      // common_config_zero
  reg  [47:0] cfg1;                      // common_config_one
  reg  [3:0]  ch_cnt;
  reg  [5:0]  line_cnt;
  reg  [47:0] rd_val;
  reg         rd_hit;
  wire        stall;

  // Read mux of readable registers and warning words
  function [48:0] read_mux;
    input [15:0] c;
    begin
      case (c)
        `CMD_CFG0_RD:      read_mux = {1'b1, cfg0};
        `CMD_CFG1_RD:      read_mux = {1'b1, cfg1};
        `CMD_OPEN_LOC_RD:  read_mux = {1'b1, open_locator};
        `CMD_SHORT_LOC_RD: read_mux = {1'b1, short_locator};
        `CMD_LINE_OPEN_HI: read_mux = {1'b1, 32'h0000_0000,
                                       line_open_warn[63:48]};
        `CMD_LINE_OPEN_LO: read_mux = {1'b1,
                                       line_open_warn[47:0]};
        `CMD_LINE_SHRT_HI: read_mux = {1'b1, 32'h0000_0000,
                                       line_short_warn[63:48]};
        `CMD_LINE_SHRT_LO: read_mux = {1'b1,
                                       line_short_warn[47:0]};
        `CMD_CH_OPEN:      read_mux = {1'b1, ch_open_warn};
        `CMD_CH_SHORT:     read_mux = {1'b1, ch_short_warn};
        default:           read_mux = 49'h0_0000_0000_0000;
      endcase
    end
  endfunction

  always @*
  begin
    {rd_hit, rd_val} = read_mux(cmd);
  end

  // A read waits while the reply register is busy or the link mid-frame,
  // so one reply never overwrites another still unsent
  assign stall      = rd_hit && (reply_pend || rx_busy);
  assign fifo_ready = !stall;

  // Synchronisers; the second stage feeds logic, sclk_s3 only as edge reference
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      sin_s1  <= 1'b1;
      sin_s2  <= 1'b1;
    end
    else
    begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sin_s1  <= sin;
      sin_s2  <= sin_s1;
    end
  end

  // Frame receive and reply shift; idle line is high, start bit low
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_busy       <= 1'b0;
      rx_cnt        <= 7'h00;
      rx_sh         <= 64'h0;
      rx_push       <= 1'b0;
      link_overflow <= 1'b0;
      reply_sh      <= 48'h0;
      reply_pend    <= 1'b0;
      sout          <= 1'b0;
    end
    else
    begin
      rx_push <= 1'b0;
      if (fifo_valid && fifo_ready && rd_hit)
      begin
        // Load reply while the link is idle
        reply_sh   <= rd_val;
        reply_pend <= 1'b1;
      end
      if (sclk_rise)
      begin
        if (!rx_busy)
        begin
          if (!sin_s2)
          begin
            rx_busy    <= 1'b1;
            rx_cnt     <= 7'h00;
            reply_pend <= 1'b0;  // Reply now goes out in this frame
          end
        end
        else
        begin
          rx_sh  <= {rx_sh[62:0], sin_s2};
          rx_cnt <= rx_cnt + 7'h01;
          if (rx_cnt == `LINK_FRAME_BITS - 7'h01)
          begin
            rx_busy <= 1'b0;
            rx_push <= 1'b1;
            // Full FIFO: the frame is lost and flagged
            if (!link_ready)
              link_overflow <= 1'b1;
          end
        end
      end
      // Data phase: reply bits on falling edges, MSB first
      if (sclk_fall && rx_busy && rx_cnt >= 7'd16)
      begin
        sout     <= reply_sh[47];
        reply_sh <= {reply_sh[46:0], 1'b0};
      end
    end
  end

  cmd_fifo #(.WIDTH(64), .DEPTH(8), .AW(3)) u_fifo
  (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (rx_push),
    .in_ready  (link_ready),
    .in_data   (rx_sh),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // ==========================================================
  // Command executor
  wire [5:0] scan_last = cfg0[`CFG0_SCAN_MSB:`CFG0_SCAN_LSB];

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg0          <= `CFG0_RESET;
      cfg1          <= `CFG1_RESET;
      open_locator  <= `LOC_RESET;
      short_locator <= `LOC_RESET;
      bank_select   <= 1'b0;
      line_cnt      <= 6'h00;
      ch_cnt        <= 4'h0;
      standby       <= 1'b0;
      psave_pulse   <= 1'b0;
      mem_we        <= 1'b0;
      mem_bank      <= 1'b0;
      mem_line      <= 6'h00;
      mem_channel   <= 4'h0;
      mem_wdata     <= 48'h0;
      frame_done    <= 1'b0;
    end
    else
    begin
      mem_we      <= 1'b0;
      psave_pulse <= 1'b0;
      frame_done  <= 1'b0;
      if (fifo_valid && fifo_ready)
      begin
        case (cmd)
          `CMD_CFG0_WR:      cfg0 <= data;
          `CMD_CFG1_WR:      cfg1 <= data;
          `CMD_OPEN_LOC_WR:  open_locator  <= data;
          `CMD_SHORT_LOC_WR: short_locator <= data;
          `CMD_FRAME_SYNC:
          begin
            line_cnt <= 6'h00;
            ch_cnt   <= 4'h0;
          end
          `CMD_MATRIX_PSAVE: psave_pulse <= 1'b1;
          `CMD_STBY_CLEAR:   standby <= 1'b0;
          `CMD_STBY_ENABLE:  standby <= 1'b1;
          `CMD_SOFT_RESET:
          begin
            // Memory port is not touched, so stored frames survive
            cfg0          <= `CFG0_RESET;
            cfg1          <= `CFG1_RESET;
            open_locator  <= `LOC_RESET;
            short_locator <= `LOC_RESET;
            bank_select   <= 1'b0;
            line_cnt      <= 6'h00;
            ch_cnt        <= 4'h0;
            standby       <= 1'b0;
          end
          `CMD_GS_WRITE:
          begin
            mem_we      <= 1'b1;
            mem_bank    <= bank_select;
            mem_line    <= line_cnt;
            mem_channel <= ch_cnt;
            mem_wdata   <= data;
            ch_cnt      <= ch_cnt + 4'h1;
            if ({1'b0, ch_cnt} == `CHANNELS_PER_LINE - 5'd1)
            begin
              ch_cnt <= 4'h0;
              // At or past the field: a shrunk scan count still ends
              if (line_cnt >= scan_last)
              begin
                line_cnt    <= 6'h00;
                bank_select <= !bank_select;
                frame_done  <= 1'b1;
              end
              else
                line_cnt <= line_cnt + 6'h01;
            end
          end
          default: ;  // Reads and unknown codes change no executor state
        endcase
      end
    end
  end

  // ==========================================================
  // Sub-period and segment timing, one grayscale clock per clk
  localparam ST_DISP = 1'b0;
  localparam ST_SWT  = 1'b1;
  reg        seg_state;
  reg  [9:0] seg_cnt;
  reg [21:0] subp_acc;   // Grayscale covered by earlier sub-periods
  wire [9:0] seg_len  = cfg1[`CFG1_SEG_MSB:`CFG1_SEG_LSB];
  wire [3:0] swt_len  = cfg1[`CFG1_SWT_MSB:`CFG1_SWT_LSB];
  wire [14:0] thr     = cfg1[`CFG1_THR_MSB:`CFG1_THR_LSB];
  wire [2:0] subp_code = cfg0[`CFG0_SUBP_MSB:`CFG0_SUBP_LSB];
  wire [6:0] subp_last = {subp_code, 4'hF};  // 16*(code+1)-1
  // Sub-period is active while earlier ones have not used up the value;
  // each active one lasts at least the threshold so the LED turns on
  wire       subp_active = ({6'h00, probe_gs} > subp_acc);
  wire [14:0] on_len = (thr == 15'h0000) ? 15'h0001 : thr;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seg_state   <= ST_DISP;
      seg_cnt     <= 10'h000;
      scan_line   <= 6'h00;
      subperiod   <= 7'h00;
      subp_acc    <= 22'h000000;
      seg_display <= 1'b0;
      line_switch <= 1'b0;
      led_on      <= 1'b0;
    end
    else if (standby)
    begin
      // Standby parks the timing at the frame start
      seg_state   <= ST_DISP;
      seg_cnt     <= 10'h000;
      scan_line   <= 6'h00;
      subperiod   <= 7'h00;
      subp_acc    <= 22'h000000;
      seg_display <= 1'b0;
      line_switch <= 1'b0;
      led_on      <= 1'b0;
    end
    else
    begin
      case (seg_state)
        ST_DISP:
        begin
          seg_display <= 1'b1;
          line_switch <= 1'b0;
          led_on <= subp_active && ({5'h00, seg_cnt} < on_len);
          seg_cnt <= seg_cnt + 10'h001;
          if (seg_cnt + 10'h001 >= seg_len)
          begin
            seg_state <= ST_SWT;
            seg_cnt   <= 10'h000;
          end
        end
        ST_SWT:
        begin
          seg_display <= 1'b0;
          line_switch <= 1'b1;
          led_on      <= 1'b0;
          seg_cnt     <= seg_cnt + 10'h001;
          if (seg_cnt + 10'h001 >= {6'h00, swt_len})
          begin
            seg_state <= ST_DISP;
            seg_cnt   <= 10'h000;
            if (scan_line >= scan_last)
            begin
              scan_line <= 6'h00;
              if (subperiod >= subp_last)
              begin
                subperiod <= 7'h00;
                subp_acc  <= 22'h000000;
              end
              else
              begin
                subperiod <= subperiod + 7'h01;
                subp_acc  <= subp_acc + {7'h00, on_len};
              end
            end
            else
              scan_line <= scan_line + 6'h01;
          end
        end
        default: seg_state <= ST_DISP;
      endcase
    end
  end
endmodule // frame_cmd

/* tb/frame_cmd_asserts.sv */
/*
  Port checker of the command interpreter: write addressing and
  display timing relations.
  Assumes a bind to frame_cmd; everything in the clk domain.
*/
`timescale 1ns/10ps
// ============================================================
// Checker
module frame_cmd_asserts
(
  // Clock and reset
  input wire       clk,
  input wire       arst_n,
  // Memory write port
  input wire       mem_we,
  input wire       mem_bank,
  input wire [5:0] mem_line,
  input wire [3:0] mem_channel,
  input wire       bank_select,
  input wire       frame_done,
  // Modes and timing
  input wire       standby,
  input wire       psave_pulse,
  input wire [5:0] scan_line,
  input wire [6:0] subperiod,
  input wire       seg_display,
  input wire       line_switch,
  input wire       led_on
);
  reg [3:0] last_ch;   // Channel of the previous write
  reg [5:0] last_line; // Line of the previous write
  // Remember where the previous word went
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last_ch   <= 4'h0;
      last_line <= 6'h00;
    end
    else if (mem_we)
    begin
      last_ch   <= mem_channel;
      last_line <= mem_line;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ch_step_a: assert property (mem_we && mem_channel != 4'h0
    |-> mem_channel == last_ch + 4'h1 && mem_line == last_line)
    else $error("Channel did not step by one");
  line_step_a: assert property (mem_we && mem_channel == 4'h0
    && mem_line != 6'h00 |-> last_ch == 4'hF
    && mem_line == last_line + 6'h01)
    else $error("Line advanced at the wrong point");
  frame_end_a: assert property (frame_done
    |-> mem_channel == 4'hF) else $error("Frame ended mid-line");
  bank_match_a: assert property (mem_we
    |-> mem_bank == $past(bank_select)) else $error("Write to wrong bank");
  seg_excl_a: assert property (line_switch
    |-> !seg_display) else $error("Display during switch");
  switch_after_a: assert property ($rose(line_switch)
    |-> $past(seg_display)) else $error("Switch without display");
  led_window_a: assert property (led_on
    |-> seg_display) else $error("LED on outside display");
  psave_pulse_a: assert property (psave_pulse
    |=> !psave_pulse) else $error("Power-save pulse too long");
  scan_step_a: assert property ($changed(scan_line)
    && scan_line != 6'h00 |-> line_switch
    && scan_line == $past(scan_line) + 6'h01)
    else $error("Scan line moved without switch");
  standby_freeze_a: assert property (standby && $past(standby)
    |-> scan_line == 6'h00 && subperiod == 7'h00)
    else $error("Timing runs in standby");
  // Main scenarios reached
  frame_c: cover property (frame_done);
  psave_c: cover property (psave_pulse);
  led_c: cover property (led_on);
endmodule // frame_cmd_asserts

/* tb/link_host.sv */
/*
  Display controller model on the serial command link.
  Assumes the device samples sin on rising sclk and replies on sout.
*/
`timescale 1ns/10ps
// ============================================================
// Link controller
module link_host
(
  // Link pins
  output reg  sclk,
  output reg  sin,
  input  wire sout
);
  // Clock stands still low, data idles high
  initial
  begin
    sclk = 1'b0;
    sin  = 1'b1;
  end
  // One frame: start bit, command, data; reply gathered meanwhile
  task xfer(input [15:0] c, input [47:0] d, output [47:0] r);
    reg [63:0] sh; // Bits still to send
    integer    i;
    begin
      #203; // Gap well above ten clocks, off the clk grid
      sh = {c, d};
      sin = 1'b0;
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
      for (i = 0; i < 64; i = i + 1)
      begin
        sin = sh[63-i]; // Most significant bit first
        #32 sclk = 1'b1;
        if (i >= 16)
          r = {r[46:0], sout}; // Reply follows the command bits
        #32 sclk = 1'b0;
      end
      sin = 1'b1; // Released line goes to its idle level
    end
  endtask
endmodule // link_host

/* tb/testbench.sv */
/*
  Self-checking bench of the command interpreter and its FIFO.
  Assumes the link controller model and the bound port checker.
*/
`timescale 1ns/10ps
`include "frame_cmd_regs.vh"
// ============================================================
// Bench top
module testbench;
  reg         clk, arst_n;             // Clock and reset
  reg  [63:0] line_open_warn, line_short_warn;
  reg  [47:0] ch_open_warn, ch_short_warn;
  reg  [15:0] probe_gs;                // Grayscale probe
  wire        sclk, sin, sout;         // Link
  wire        link_ready, link_overflow, mem_we, mem_bank;
  wire [5:0]  mem_line, scan_line;
  wire [3:0]  mem_channel;
  wire [47:0] mem_wdata, open_locator, short_locator;
  wire        bank_select, frame_done, standby, psave_pulse;
  wire [6:0]  subperiod;
  wire        seg_display, line_switch, led_on;
  integer     bad_count, num_checks, n_fd, n_ps;
  reg  [31:0] lfsr;                    // Random source
  reg  [95:0] t;
  reg  [47:0] d, junk, cfg;
  reg  [15:0] wi;
  reg         eb;                      // Expected bank
  reg  [5:0]  el, sc, mx_ln;           // Expected line, scan field
  reg  [3:0]  ec;                      // Expected channel
  reg  [6:0]  mx_sp;
  logic [58:0] exp_q[$];               // Expected memory writes
  frame_cmd uut
  (
    .clk, .arst_n, .sclk, .sin, .sout, .link_ready, .link_overflow,
    .mem_we, .mem_bank, .mem_line, .mem_channel, .mem_wdata,
    .bank_select, .frame_done, .line_open_warn, .line_short_warn,
    .ch_open_warn, .ch_short_warn, .open_locator, .short_locator,
    .standby, .psave_pulse, .probe_gs, .scan_line, .subperiod,
    .seg_display, .line_switch, .led_on
  );
  link_host host (.sclk, .sin, .sout);
  // ============================================================
  // Helpers
  function automatic logic [47:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
    rnd[47:16] = lfsr;
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
    rnd[15:0] = lfsr[15:0];
  endfunction
  // Reply expected for each warning read
  function [47:0] wexp(input [15:0] i);
    case (i)
      16'h0: wexp = {32'h0, line_open_warn[63:48]};
      16'h1: wexp = line_open_warn[47:0];
      16'h2: wexp = {32'h0, line_short_warn[63:48]};
      16'h3: wexp = line_short_warn[47:0];
      16'h4: wexp = ch_open_warn;
      default: wexp = ch_short_warn;
    endcase
  endfunction
  task check(input string n, input [63:0] e, input [63:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        bad_count = bad_count + 1;
        $display("ERROR %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Writes land a few clocks after the frame ends
  task settle;
    repeat (10) @(posedge clk);
  endtask
  // Read: reply comes out during the next frame
  task rd(input [15:0] c, input [47:0] e, input string n);
    reg [47:0] r;
    begin
      host.xfer(c, 48'h0, r);
      host.xfer(16'h0000, 48'h0, r);
      check(n, e, r);
    end
  endtask
  task sync;
    begin
      host.xfer(`CMD_FRAME_SYNC, 48'h0, junk);
      el = 6'h00;
      ec = 4'h0;
    end
  endtask
  // Grayscale word: note its destination, then step the counters
  task gs;
    begin
      d = rnd();
      exp_q.push_back({eb, el, ec, d});
      host.xfer(`CMD_GS_WRITE, d, junk);
      ec = ec + 4'h1;
      if (ec == 4'h0 && el == sc)
      begin
        el = 6'h00;
        eb = ~eb;
      end
      else if (ec == 4'h0)
        el = el + 6'h01;
    end
  endtask
  // ============================================================
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #500_000;
    bad_count = bad_count + 1;
    end_sim;
  end
  // Output watcher: writes against the oldest note
  always @(posedge clk)
  begin
    if (mem_we === 1'b1 && exp_q.size() == 0)
      check("mem_extra", 64'h0, 64'h1);
    else if (mem_we === 1'b1)
      check("mem_write", exp_q.pop_front(),
            {mem_bank, mem_line, mem_channel, mem_wdata});
    if (psave_pulse === 1'b1)
      n_ps = n_ps + 1;
    if (frame_done === 1'b1)
      n_fd = n_fd + 1;
    if (scan_line > mx_ln)
      mx_ln = scan_line;
    if (subperiod > mx_sp)
      mx_sp = subperiod;
  end
  // ============================================================
  // Main sequence
  initial
  begin
    {bad_count, num_checks, n_fd, n_ps} = 128'h0;
    {arst_n, probe_gs} = 17'h0;
    {line_open_warn, line_short_warn} = 128'h0;
    {ch_open_warn, ch_short_warn} = 96'h0;
    {eb, el, ec, sc, mx_ln, mx_sp} = 30'h0;
    lfsr = 32'hFE8682F9;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t = {rnd(), rnd()};
    line_open_warn <= t[63:0];
    probe_gs <= t[79:64];
    t = {rnd(), rnd()};
    line_short_warn <= t[63:0];
    ch_open_warn <= rnd();
    ch_short_warn <= rnd();
    settle;
    check("bank_select", 1'b0, bank_select);
    rd(`CMD_CFG0_RD, `CFG0_RESET, "cfg0");
    $display("test reset done");
    sync;
    repeat (16) gs;
    settle;
    check("frames", 1, n_fd);
    check("bank_select", 1'b1, bank_select);
    $display("test first frame done");
    // Two lines, 128 sub-periods, sync again mid-line
    cfg = `CFG0_RESET;
    cfg[21:16] = 6'h01;
    cfg[24:22] = 3'h7;
    host.xfer(`CMD_CFG0_WR, cfg, junk);
    sc = 6'h01;
    rd(`CMD_CFG0_RD, cfg, "cfg0");
    sync;
    repeat (3) gs;
    sync;
    mx_ln = 6'h00;
    mx_sp = 7'h00;
    repeat (32) gs;
    settle;
    check("frames", 2, n_fd);
    check("bank_select", 1'b0, bank_select);
    check("last_line", 1, mx_ln);
    check("last_subp", 127, mx_sp);
    $display("test two-line frame done");
    d = rnd();
    host.xfer(`CMD_OPEN_LOC_WR, d, junk);
    rd(`CMD_OPEN_LOC_RD, d, "open_loc");
    check("open_locator", d, open_locator);
    d = rnd();
    host.xfer(`CMD_SHORT_LOC_WR, d, junk);
    rd(`CMD_SHORT_LOC_RD, d, "short_loc");
    for (wi = 0; wi < 6; wi = wi + 1)
      rd(`CMD_LINE_OPEN_HI + wi, wexp(wi), "warn");
    $display("test readback done");
    host.xfer(`CMD_MATRIX_PSAVE, 48'h0, junk);
    settle;
    check("psave", 1, n_ps);
    host.xfer(`CMD_STBY_ENABLE, 48'h0, junk);
    settle;
    check("standby", 1'b1, standby);
    host.xfer(`CMD_STBY_CLEAR, 48'h0, junk);
    settle;
    check("standby", 1'b0, standby);
    gs;
    gs;
    host.xfer(`CMD_SOFT_RESET, 48'h0, junk);
    {eb, el, ec, sc} = 17'h0;
    settle;
    check("open_locator", 48'h0, open_locator);
    rd(`CMD_CFG0_RD, `CFG0_RESET, "cfg0");
    gs;
    settle;
    check("pending", 0, exp_q.size());
    $display("test modes done");
    // FIFO seen through the link: every frame queued, none dropped
    check("link_ready", 1'b1, link_ready);
    check("link_overflow", 1'b0, link_overflow);
    $display("test fifo done");
    end_sim;
  end
endmodule // testbench
bind frame_cmd frame_cmd_asserts chk
(
  .clk, .arst_n, .mem_we, .mem_bank, .mem_line, .mem_channel,
  .bank_select, .frame_done, .standby, .psave_pulse, .scan_line,
  .subperiod, .seg_display, .line_switch, .led_on
);
